// [uart_lms_params.svh]
// Offsets, bit positions, reset values and counts of the line and modem status block.
`ifndef UART_LMS_PARAMS_SVH
`define UART_LMS_PARAMS_SVH
`define OFF_DATA        4'h0
`define OFF_IRQ_EN      4'h1
`define OFF_MODEM_CTRL  4'h4
`define OFF_LINE_STAT   4'h5
`define OFF_MODEM_STAT  4'h6
`define OFF_FEAT_CTRL   4'h8
`define OFF_ENH_FEAT    4'h9
`define MC_DTR          0
`define MC_RTS          1
`define MC_LOOP_RI      2
`define MC_LOOP_CD      3
`define MC_LOOP         4
`define MC_IR           6
`define MC_PRESC        7
`define IE_THR          1
`define IE_LINE         2
`define IE_MODEM        3
`define FC_RX_INV       4
`define EF_AUTO_CTS     7
`define REG_RST         8'h00
`define PRESC_LAST      2'h3
`endif

// [uart_lms_pkg.sv]
// Types shared by the line and modem status block.
package uart_lms_pkg;
    typedef struct packed {
        logic       brk;
        logic       fe;
        logic       pe;
        logic [7:0] data;
    } rx_char_t;
    typedef struct packed {
        logic cd;
        logic ri;
        logic dsr;
        logic cts;
    } modem_t;
endpackage

// [uart_line_modem_status.sv]
// Line status, modem status and modem control logic of one serial channel.
// Operation
// - Infrared select loads strap level after reset
// - Infrared mode routes line, transmit idles low
// - Receive invert bit flips input before decoder in infrared mode only
// - Prescaler bit selects divide by one or four
// - Line interrupt on any receive FIFO error
// - Data ready while receive FIFO holds characters
// - Full FIFO arrival sets overrun, drops character
// - Parity error belongs to head character
// - Framing error belongs to head character
// - Break flagged once, held until line high
// - Holding empty set when transmit buffer empties
// - Transmit interrupt while holding empty and enabled
// - Transmitter empty when buffer and shifter idle
// - FIFO error flag while errored characters remain
// - Change flags set on modem level changes
// - Ring change flag only on ring end
// - Auto clear-to-send pauses after current character unless ring loopback bit set
// - Clear-to-send status inverts pin or loops back
// - Data-set-ready status inverts pin or loops back
// - Ring status inverts pin or loops back
// - Carrier status inverts pin or loops back
// - Loopback bit selects loopback substitutions
`include "uart_lms_params.svh"
`timescale 1ns/1ps
`default_nettype none
module uart_line_modem_status
    import uart_lms_pkg::*;
#(
    parameter int RX_DEPTH = 64,
    parameter int TX_DEPTH = 2
) (
    input  wire logic       I_CLK,
    input  wire logic       I_SYS_RST,
    input  wire logic       I_CS,
    input  wire logic       I_RD,
    input  wire logic       I_WR,
    input  wire logic [3:0] I_ADDR,
    input  wire logic [7:0] I_WDATA,
    output logic      [7:0] O_RDATA,
    input  wire logic       I_RX_VALID,
    input  wire rx_char_t   I_RX_CHAR,
    output logic            O_TX_VALID,
    output logic      [7:0] O_TX_DATA,
    input  wire logic       I_TX_READY,
    input  wire logic       I_TX_BUSY,
    output logic            O_TX_SPACE,
    input  wire logic       I_TX_SER,
    input  wire logic       I_IR_PULSE,
    output logic            O_TX_PIN,
    input  wire logic       I_RX_PIN,
    output logic            O_RX_SER,
    output logic            O_BAUD_TICK,
    input  wire logic       I_CTS_N,
    input  wire logic       I_DSR_N,
    input  wire logic       I_RI_N,
    input  wire logic       I_CD_N,
    output logic            O_RTS_N,
    output logic            O_DTR_N,
    input  wire logic       I_IR_STRAP,
    output logic            O_IR_MODE,
    output logic            O_LSR_IRQ,
    output logic            O_THR_IRQ,
    output logic            O_MSR_IRQ
);
    localparam int RXW = $clog2(RX_DEPTH + 1);
    localparam int RXA = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
    localparam int TXW = $clog2(TX_DEPTH + 1);

    function automatic logic has_err(input rx_char_t c);
        has_err = c.pe | c.fe | c.brk;
    endfunction

    function automatic logic [RXA-1:0] ptr_inc(input logic [RXA-1:0] p);
        ptr_inc = (p == RXA'(RX_DEPTH - 1)) ? '0 : RXA'(p + 1'b1);
    endfunction

    logic [7:0]     modem_ctrl_reg_r;
    logic [7:0]     irq_enable_reg_r;
    logic [7:0]     feature_ctrl_reg_r;
    logic [7:0]     enhanced_feature_reg_r;
    logic           strap_pend_r;
    logic           overrun_r;
    logic           brk_seen_r;
    logic [1:0]     presc_cnt_r;
    modem_t         prev_r;
    logic           prev_ok_r;
    logic [3:0]     delta_r;
    rx_char_t       rx_mem_r [RX_DEPTH];
    logic [RXA-1:0] rx_wr_r;
    logic [RXA-1:0] rx_rd_r;
    logic [RXW-1:0] rx_cnt_r;
    logic [RXW-1:0] err_cnt_r;
    logic [7:0]     tx_ent_r [TX_DEPTH];
    logic [TXW-1:0] tx_cnt_r;

    // Bus decode.
    wire wr_any   = I_CS & I_WR;
    wire rd_any   = I_CS & I_RD;
    wire wr_data  = wr_any & (I_ADDR == `OFF_DATA);
    wire wr_mc    = wr_any & (I_ADDR == `OFF_MODEM_CTRL);
    wire rd_data  = rd_any & (I_ADDR == `OFF_DATA);
    wire rd_lsr   = rd_any & (I_ADDR == `OFF_LINE_STAT);
    wire rd_msr   = rd_any & (I_ADDR == `OFF_MODEM_STAT);
    wire loop_on  = modem_ctrl_reg_r[`MC_LOOP];
    wire ir_on    = modem_ctrl_reg_r[`MC_IR];

    // Modem status levels with loopback substitution.
    modem_t modem_now;
    assign modem_now.cts = loop_on ? modem_ctrl_reg_r[`MC_RTS] : ~I_CTS_N;
    assign modem_now.dsr = loop_on ? modem_ctrl_reg_r[`MC_DTR] : ~I_DSR_N;
    assign modem_now.ri  = loop_on ? modem_ctrl_reg_r[`MC_LOOP_RI] : ~I_RI_N;
    assign modem_now.cd  = loop_on ? modem_ctrl_reg_r[`MC_LOOP_CD] : ~I_CD_N;
    wire [3:0] chg = modem_now ^ prev_r;
    // Ring end: the pin rises, so the complemented status bit falls.
    wire [3:0] delta_set = prev_ok_r ?
        {chg[3], prev_r.ri & ~modem_now.ri, chg[1], chg[0]} : 4'h0;
    wire [3:0] delta_nxt = delta_set | (rd_msr ? 4'h0 : delta_r);

    // Receive FIFO; a full FIFO drops the new character, never an old one.
    wire      rx_full  = (rx_cnt_r == RXW'(RX_DEPTH));
    wire      rx_dr    = (rx_cnt_r != '0);
    rx_char_t rx_head;
    assign rx_head     = rx_mem_r[rx_rd_r];
    wire      rx_pop   = rd_data & rx_dr;
    wire      rx_drop  = I_RX_CHAR.brk & brk_seen_r;
    wire      rx_push  = I_RX_VALID & ~rx_full & ~rx_drop;
    wire      ovr_set  = I_RX_VALID & rx_full & ~rx_drop;
    wire      push_err = rx_push & has_err(I_RX_CHAR);
    wire      pop_err  = rx_pop & has_err(rx_head);
    wire [RXW-1:0] rx_cnt_nxt =
        RXW'(rx_cnt_r + {{(RXW-1){1'b0}}, rx_push} - {{(RXW-1){1'b0}}, rx_pop});
    wire [RXW-1:0] err_cnt_nxt =
        RXW'(err_cnt_r + {{(RXW-1){1'b0}}, push_err}
             - {{(RXW-1){1'b0}}, pop_err});

    // Transmit buffer: entry 0 is always the head, so the data port is a flop.
    wire           tx_full   = (tx_cnt_r == TXW'(TX_DEPTH));
    wire           tx_push   = wr_data & ~tx_full;
    wire           tx_pop    = O_TX_VALID & I_TX_READY;
    wire [TXW-1:0] tx_cnt_nxt =
        TXW'(tx_cnt_r + {{(TXW-1){1'b0}}, tx_push} - {{(TXW-1){1'b0}}, tx_pop});
    wire [TXW-1:0] tx_widx   = tx_pop ? TXW'(tx_cnt_r - 1'b1) : tx_cnt_r;
    assign O_TX_DATA = tx_ent_r[0];
    // The shifter only takes a character at a frame boundary, so withdrawing
    // valid here lets the character already in flight finish.
    wire cts_pause = enhanced_feature_reg_r[`EF_AUTO_CTS]
                   & ~modem_ctrl_reg_r[`MC_LOOP_RI] & ~modem_now.cts;
    wire thr_empty = (tx_cnt_r == '0);
    wire tx_idle   = thr_empty & ~I_TX_BUSY;

    // Line path through the infrared encoder and decoder.
    wire rx_lvl    = feature_ctrl_reg_r[`FC_RX_INV] ? ~I_RX_PIN : I_RX_PIN;
    wire rx_nxt    = ir_on ? ~rx_lvl : I_RX_PIN;
    wire tx_pin_nxt = ir_on ? (~I_TX_SER & I_IR_PULSE) : I_TX_SER;
    wire tick_nxt  = ~modem_ctrl_reg_r[`MC_PRESC]
                   | (presc_cnt_r == `PRESC_LAST);

    wire [7:0] lsr_val = {err_cnt_r != '0, tx_idle, thr_empty,
                          brk_seen_r | (rx_dr & rx_head.brk),
                          rx_dr & rx_head.fe, rx_dr & rx_head.pe,
                          overrun_r, rx_dr};
    wire [7:0] msr_val = {modem_now, delta_r};
    wire [7:0] rd_mux =
        (I_ADDR == `OFF_DATA)       ? (rx_dr ? rx_head.data : 8'h00) :
        (I_ADDR == `OFF_IRQ_EN)     ? irq_enable_reg_r :
        (I_ADDR == `OFF_MODEM_CTRL) ? modem_ctrl_reg_r :
        (I_ADDR == `OFF_LINE_STAT)  ? lsr_val :
        (I_ADDR == `OFF_MODEM_STAT) ? msr_val :
        (I_ADDR == `OFF_FEAT_CTRL)  ? feature_ctrl_reg_r :
        (I_ADDR == `OFF_ENH_FEAT)   ? enhanced_feature_reg_r : 8'h00;
    wire [7:0] mc_nxt = wr_mc ? I_WDATA :
        {modem_ctrl_reg_r[7], strap_pend_r ? I_IR_STRAP : ir_on,
         modem_ctrl_reg_r[5:0]};

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            modem_ctrl_reg_r       <= `REG_RST;
            irq_enable_reg_r       <= `REG_RST;
            feature_ctrl_reg_r     <= `REG_RST;
            enhanced_feature_reg_r <= `REG_RST;
            strap_pend_r           <= 1'b1;
        end else begin
            strap_pend_r     <= 1'b0;
            modem_ctrl_reg_r <= mc_nxt;
            if (wr_any && I_ADDR == `OFF_IRQ_EN) begin
                irq_enable_reg_r <= I_WDATA;
            end
            if (wr_any && I_ADDR == `OFF_FEAT_CTRL) begin
                feature_ctrl_reg_r <= I_WDATA;
            end
            if (wr_any && I_ADDR == `OFF_ENH_FEAT) begin
                enhanced_feature_reg_r <= I_WDATA;
            end
        end
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            overrun_r  <= 1'b0;
            brk_seen_r <= 1'b0;
            rx_wr_r    <= '0;
            rx_rd_r    <= '0;
            rx_cnt_r   <= '0;
            err_cnt_r  <= '0;
        end else begin
            overrun_r  <= ovr_set | (overrun_r & ~rd_lsr);
            brk_seen_r <= (rx_push & I_RX_CHAR.brk)
                        | (brk_seen_r & ~O_RX_SER);
            rx_cnt_r   <= rx_cnt_nxt;
            err_cnt_r  <= err_cnt_nxt;
            if (rx_push) begin
                rx_wr_r <= ptr_inc(rx_wr_r);
            end
            if (rx_pop) begin
                rx_rd_r <= ptr_inc(rx_rd_r);
            end
        end
    end

    // Storage needs no reset; unread entries are masked by the count.
    always_ff @(posedge I_CLK) begin
        if (rx_push) begin
            rx_mem_r[rx_wr_r] <= I_RX_CHAR;
        end
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            tx_cnt_r <= '0;
            for (int i = 0; i < TX_DEPTH; i++) begin
                tx_ent_r[i] <= 8'h00;
            end
        end else begin
            tx_cnt_r <= tx_cnt_nxt;
            for (int i = 0; i < TX_DEPTH; i++) begin
                if (tx_push && tx_widx == TXW'(i)) begin
                    tx_ent_r[i] <= I_WDATA;
                end else if (tx_pop && i < TX_DEPTH - 1) begin
                    tx_ent_r[i] <= tx_ent_r[i + 1];
                end
            end
        end
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            presc_cnt_r <= 2'h0;
            prev_r      <= '0;
            prev_ok_r   <= 1'b0;
            delta_r     <= 4'h0;
        end else begin
            presc_cnt_r <= 2'(presc_cnt_r + 1'b1);
            prev_r      <= modem_now;
            prev_ok_r   <= 1'b1;
            delta_r     <= delta_nxt;
        end
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_RDATA     <= 8'h00;
            O_TX_VALID  <= 1'b0;
            O_TX_SPACE  <= 1'b0;
            O_TX_PIN    <= 1'b1;
            O_RX_SER    <= 1'b1;
            O_BAUD_TICK <= 1'b0;
            O_RTS_N     <= 1'b1;
            O_DTR_N     <= 1'b1;
            O_IR_MODE   <= 1'b0;
            O_LSR_IRQ   <= 1'b0;
            O_THR_IRQ   <= 1'b0;
            O_MSR_IRQ   <= 1'b0;
        end else begin
            if (rd_any) begin
                O_RDATA <= rd_mux;
            end
            O_TX_VALID  <= (tx_cnt_nxt != '0) & ~cts_pause;
            O_TX_SPACE  <= (tx_cnt_nxt != TXW'(TX_DEPTH));
            O_TX_PIN    <= tx_pin_nxt;
            O_RX_SER    <= rx_nxt;
            O_BAUD_TICK <= tick_nxt;
            O_RTS_N     <= ~mc_nxt[`MC_RTS] | mc_nxt[`MC_LOOP];
            O_DTR_N     <= ~mc_nxt[`MC_DTR] | mc_nxt[`MC_LOOP];
            O_IR_MODE   <= mc_nxt[`MC_IR];
            O_LSR_IRQ   <= irq_enable_reg_r[`IE_LINE]
                         & ((err_cnt_nxt != '0) | ovr_set | overrun_r);
            O_THR_IRQ   <= irq_enable_reg_r[`IE_THR] & thr_empty;
            O_MSR_IRQ   <= irq_enable_reg_r[`IE_MODEM] & (delta_nxt != 4'h0);
        end
    end

    property p_strap;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        (strap_pend_r && !wr_mc) |=> (ir_on == $past(I_IR_STRAP));
    endproperty
    a_strap: assert property (p_strap) else $error("strap not loaded");

    property p_ir_idle;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        (ir_on && I_TX_SER) |=> !O_TX_PIN;
    endproperty
    a_ir_idle: assert property (p_ir_idle) else $error("ir idle high");

    property p_div1;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        !modem_ctrl_reg_r[`MC_PRESC] |=> O_BAUD_TICK;
    endproperty
    a_div1: assert property (p_div1) else $error("tick missing");

    property p_div4;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        (modem_ctrl_reg_r[`MC_PRESC] && $past(modem_ctrl_reg_r[`MC_PRESC])
         && O_BAUD_TICK && !wr_mc)
            |=> !O_BAUD_TICK;
    endproperty
    a_div4: assert property (p_div4) else $error("tick too fast");

    property p_dready;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        rd_lsr |=> (O_RDATA[0] == ($past(rx_cnt_r) != '0));
    endproperty
    a_dready: assert property (p_dready) else $error("data ready wrong");

    property p_overrun;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        (I_RX_VALID && rx_full && !rx_drop && !rx_pop)
            |=> (overrun_r && rx_cnt_r == $past(rx_cnt_r));
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun lost");

    property p_thr_irq;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        (irq_enable_reg_r[`IE_THR] && tx_cnt_r == '0) |=> O_THR_IRQ;
    endproperty
    a_thr_irq: assert property (p_thr_irq) else $error("no tx irq");

    property p_err_sum;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        (rx_cnt_r == '0) |-> (err_cnt_r == '0);
    endproperty
    a_err_sum: assert property (p_err_sum) else $error("stale error");

    property p_dcts;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        ($past(prev_ok_r) && !loop_on && !$past(loop_on) && $changed(I_CTS_N))
            |=> delta_r[0];
    endproperty
    a_dcts: assert property (p_dcts) else $error("cts change lost");

    property p_ring_end;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        ($fell(I_RI_N) && !loop_on && !$past(loop_on) && !delta_r[2])
            |=> !delta_r[2];
    endproperty
    a_ring_end: assert property (p_ring_end) else $error("ring edge");

    property p_cts_pause;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        cts_pause |=> !O_TX_VALID;
    endproperty
    a_cts_pause: assert property (p_cts_pause) else $error("cts ignored");

    property p_rd_clear;
        @(posedge I_CLK) disable iff (I_SYS_RST)
        (rd_msr && delta_set == 4'h0) |=> (delta_r == 4'h0);
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("delta kept");
endmodule
`default_nettype wire

// [uart_lms_remote.sv]
// Remote serial party model: transmit shifter and modem handshake lines.
`timescale 1ns/1ps
`default_nettype none
module uart_lms_remote
    import uart_lms_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_stall,
    input  wire modem_t     i_active,
    input  wire logic       i_tx_valid,
    input  wire logic [7:0] i_tx_data,
    output logic            o_tx_ready,
    output logic            o_tx_busy,
    output logic            o_tx_ser,
    output logic            o_cts_n,
    output logic            o_dsr_n,
    output logic            o_ri_n,
    output logic            o_cd_n,
    output logic      [7:0] o_got,
    output logic      [7:0] o_cnt
);
    logic [3:0] bits_r;
    logic [7:0] shift_r;
    wire        take = i_tx_valid && o_tx_ready;
    assign o_tx_busy = (bits_r != 4'h0);
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_tx_ready <= 1'b0;
            o_tx_ser   <= 1'b1;
            {o_cts_n, o_dsr_n, o_ri_n, o_cd_n} <= 4'hf;
            o_got      <= 8'h00;
            o_cnt      <= 8'h00;
            bits_r     <= 4'h0;
            shift_r    <= 8'h00;
        end else begin
            // A high clear-to-send asks the sender to pause after its character.
            o_cts_n    <= ~i_active.cts;
            o_dsr_n    <= ~i_active.dsr;
            o_ri_n     <= ~i_active.ri;
            o_cd_n     <= ~i_active.cd;
            // Ready is withheld for a whole character so the shifter stalls honestly.
            o_tx_ready <= !i_stall && !o_tx_busy && !take;
            o_tx_ser   <= o_tx_busy ? shift_r[0] : 1'b1;
            if (take) begin
                o_got   <= i_tx_data;
                o_cnt   <= o_cnt + 8'h01;
                shift_r <= i_tx_data;
                bits_r  <= 4'h8;
            end else if (o_tx_busy) begin
                bits_r  <= bits_r - 4'h1;
                shift_r <= {1'b1, shift_r[7:1]};
            end
        end
    end
endmodule
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the line and modem status block.
`include "uart_lms_params.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench
    import uart_lms_pkg::*;
;
    logic clk, rst, cs, rd_s, wr_s, rx_valid, rx_pin, stall;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, tx_data, got, cnt, d;
    rx_char_t rx_char;
    modem_t act;
    logic tx_valid, tx_ready, tx_busy, tx_space, tx_ser, tx_pin, rx_ser;
    logic tick, cts_n, dsr_n, ri_n, cd_n, rts_n, dtr_n, ir_mode;
    logic lsr_irq, thr_irq, msr_irq;
    int failures, total_checks, n;
    uart_line_modem_status #(.RX_DEPTH(4), .TX_DEPTH(2)) DUT (
        .I_CLK(clk), .I_SYS_RST(rst), .I_CS(cs), .I_RD(rd_s), .I_WR(wr_s),
        .I_ADDR(addr), .I_WDATA(wdata), .O_RDATA(rdata),
        .I_RX_VALID(rx_valid), .I_RX_CHAR(rx_char), .O_TX_VALID(tx_valid),
        .O_TX_DATA(tx_data), .I_TX_READY(tx_ready), .I_TX_BUSY(tx_busy),
        .O_TX_SPACE(tx_space), .I_TX_SER(tx_ser), .I_IR_PULSE(1'b1),
        .O_TX_PIN(tx_pin), .I_RX_PIN(rx_pin), .O_RX_SER(rx_ser),
        .O_BAUD_TICK(tick), .I_CTS_N(cts_n), .I_DSR_N(dsr_n), .I_RI_N(ri_n),
        .I_CD_N(cd_n), .O_RTS_N(rts_n), .O_DTR_N(dtr_n), .I_IR_STRAP(1'b1),
        .O_IR_MODE(ir_mode), .O_LSR_IRQ(lsr_irq), .O_THR_IRQ(thr_irq),
        .O_MSR_IRQ(msr_irq));
    uart_lms_remote far_end (
        .i_clk(clk), .i_rst(rst), .i_stall(stall), .i_active(act),
        .i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_tx_ready(tx_ready),
        .o_tx_busy(tx_busy), .o_tx_ser(tx_ser), .o_cts_n(cts_n),
        .o_dsr_n(dsr_n), .o_ri_n(ri_n), .o_cd_n(cd_n), .o_got(got),
        .o_cnt(cnt));
    always #2 clk = ~clk;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen,
                     exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(negedge clk);
        {cs, wr_s, addr, wdata} = {1'b1, 1'b1, a, v};
        @(negedge clk);
        {cs, wr_s} = 2'b00;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
        @(negedge clk);
        {cs, rd_s, addr} = {1'b1, 1'b1, a};
        @(negedge clk);
        {cs, rd_s} = 2'b00;
        check(rdata, exp);
    endtask
    task automatic push(input logic [2:0] err, input logic [7:0] v);
        @(negedge clk);
        rx_valid = 1'b1;
        rx_char = {err, v};
        @(negedge clk);
        rx_valid = 1'b0;
    endtask
    task automatic gap(input int c);
        repeat (c) @(negedge clk);
    endtask
    task automatic wait_cnt(input logic [7:0] want);
        n = 0;
        while (cnt !== want && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n == 200) begin
            failures++;
            $display("CHECK FAILED at %0t: transmit wait ran out", $time);
        end
    endtask
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        complete_run();
    end
    initial begin
        {clk, cs, rd_s, wr_s, rx_valid, stall} = 6'h00;
        {addr, wdata, rx_char, act} = '0;
        {rst, rx_pin} = 2'b11;
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        rdc(`OFF_MODEM_CTRL, 8'h40);
        check({7'h00, tx_pin}, 8'h00);
        check({7'h00, rx_ser}, 8'h00);
        wr(`OFF_FEAT_CTRL, 8'h10);
        gap(2);
        check({7'h00, rx_ser}, 8'h01);
        wr(`OFF_FEAT_CTRL, 8'h00);
        wr(`OFF_MODEM_CTRL, 8'h00);
        gap(2);
        check({6'h00, ir_mode, tx_pin}, 8'h01);
        // Modem inputs: change flags, ring end only, read clear, loopback.
        rdc(`OFF_MODEM_STAT, 8'h00);
        wr(`OFF_IRQ_EN, 8'h08);
        act = 4'b1011;
        gap(4);
        check({7'h00, msr_irq}, 8'h01);
        rdc(`OFF_MODEM_STAT, 8'hbb);
        rdc(`OFF_MODEM_STAT, 8'hb0);
        gap(2);
        check({7'h00, msr_irq}, 8'h00);
        act.ri = 1'b1;
        gap(3);
        rdc(`OFF_MODEM_STAT, 8'hf0);
        act.ri = 1'b0;
        gap(3);
        rdc(`OFF_MODEM_STAT, 8'hb4);
        wr(`OFF_MODEM_CTRL, 8'h1b);
        gap(3);
        rdc(`OFF_MODEM_STAT, 8'hb0);
        check({6'h00, rts_n, dtr_n}, 8'h03);
        wr(`OFF_MODEM_CTRL, 8'h12);
        gap(3);
        rdc(`OFF_MODEM_STAT, 8'h1a);
        act = 4'b0000;
        wr(`OFF_MODEM_CTRL, 8'h03);
        gap(3);
        check({6'h00, rts_n, dtr_n}, 8'h00);
        rdc(`OFF_MODEM_STAT, 8'h01);
        rdc(`OFF_MODEM_STAT, 8'h00);
        // Receive path: error flags belong to the head character.
        wr(`OFF_IRQ_EN, 8'h04);
        push(3'b001, 8'ha5);
        gap(1);
        check({7'h00, lsr_irq}, 8'h01);
        rdc(`OFF_LINE_STAT, 8'he5);
        rdc(`OFF_DATA, 8'ha5);
        rdc(`OFF_LINE_STAT, 8'h60);
        push(3'b010, 8'h3c);
        rdc(`OFF_LINE_STAT, 8'he9);
        rdc(`OFF_DATA, 8'h3c);
        for (int i = 0; i < 5; i++) push(3'b000, 8'h10 + 8'(i));
        rdc(`OFF_LINE_STAT, 8'h63);
        rdc(`OFF_LINE_STAT, 8'h61);
        for (int i = 0; i < 4; i++) rdc(`OFF_DATA, 8'h10 + 8'(i));
        rdc(`OFF_DATA, 8'h00);
        rx_pin = 1'b0;
        gap(2);
        push(3'b100, 8'h00);
        push(3'b100, 8'h00);
        push(3'b000, 8'h77);
        rdc(`OFF_LINE_STAT, 8'hf1);
        rdc(`OFF_DATA, 8'h00);
        rdc(`OFF_DATA, 8'h77);
        rx_pin = 1'b1;
        gap(3);
        rdc(`OFF_LINE_STAT, 8'h60);
        // Transmit buffer: fill until refused while the shifter stalls.
        stall = 1'b1;
        wr(`OFF_IRQ_EN, 8'h02);
        gap(1);
        check({7'h00, thr_irq}, 8'h01);
        wr(`OFF_DATA, 8'h5a);
        wr(`OFF_DATA, 8'hc3);
        check({7'h00, tx_space}, 8'h00);
        wr(`OFF_DATA, 8'h99);
        rdc(`OFF_LINE_STAT, 8'h00);
        check({7'h00, thr_irq}, 8'h00);
        stall = 1'b0;
        wait_cnt(8'h01);
        check(got, 8'h5a);
        wait_cnt(8'h02);
        check(got, 8'hc3);
        rdc(`OFF_LINE_STAT, 8'h20);
        gap(20);
        check(cnt, 8'h02);
        rdc(`OFF_LINE_STAT, 8'h60);
        wr(`OFF_ENH_FEAT, 8'h80);
        gap(3);
        wr(`OFF_DATA, 8'h3e);
        gap(12);
        check(cnt, 8'h02);
        act.cts = 1'b1;
        wait_cnt(8'h03);
        check(got, 8'h3e);
        wr(`OFF_ENH_FEAT, 8'h00);
        // Baud tick rate with and without the prescaler.
        for (int p = 0; p < 2; p++) begin
            wr(`OFF_MODEM_CTRL, p == 0 ? 8'h00 : 8'h80);
            gap(2);
            d = 8'h00;
            repeat (16) begin
                @(negedge clk);
                d = d + {7'h00, tick};
            end
            check(d, p == 0 ? 8'h10 : 8'h04);
        end
        complete_run();
    end
endmodule
`default_nettype wire
